//--- aoc_pkg.sv
// Package for the angle output conditioning chain: register map, fields, types.
// Assumes one sample clock domain and a plain address/strobe register port.
package aoc_pkg;

  // ==========================================================================
  // Configuration word indices (register port address, bit 7 clear)
  localparam int         CFG_DEPTH    = 128;
  localparam logic [6:0] I_OFF_POLY   = 7'h00;  // 3 channels x 3 coefficients
  localparam logic [6:0] I_GAIN_POLY  = 7'h09;  // 3 channels x 3 coefficients
  localparam logic [6:0] I_ZERO_POLY  = 7'h12;  // constant, linear, quadratic
  localparam logic [6:0] I_SCALE_GAIN = 7'h15;
  localparam logic [6:0] I_SCALE_OFF  = 7'h16;
  localparam logic [6:0] I_DATAPATH   = 7'h17;
  localparam logic [6:0] I_FRONTEND   = 7'h18;
  localparam logic [6:0] I_PROTO_TWO  = 7'h19;
  localparam logic [6:0] I_NOISE_CFG  = 7'h1a;
  localparam logic [6:0] I_OUT_OFF    = 7'h1b;
  localparam logic [6:0] I_OUT_GAIN   = 7'h1c;
  localparam logic [6:0] I_OUT_LO     = 7'h1d;
  localparam logic [6:0] I_OUT_HI     = 7'h1e;
  localparam logic [6:0] I_SPD_OFF    = 7'h1f;
  localparam logic [6:0] I_SPD_GAIN   = 7'h20;
  localparam logic [6:0] I_SPD_LO     = 7'h21;
  localparam logic [6:0] I_SPD_HI     = 7'h22;
  localparam logic [6:0] I_SUPPLY     = 7'h23;
  localparam logic [6:0] I_PX_BASE    = 7'h30;  // point x, 33 words
  localparam logic [6:0] I_PY_BASE    = 7'h58;  // point y, 33 words
  localparam int         NPTS_ONE     = 33;
  localparam int         NPTS_TWO     = 17;

  // Status words (register port address, bit 7 set), read only
  localparam logic [7:0] A_ST_OUT     = 8'h80;
  localparam logic [7:0] A_ST_SPEED   = 8'h81;
  localparam logic [7:0] A_ST_LIN     = 8'h82;
  localparam logic [7:0] A_ST_NOISE   = 8'h83;
  localparam logic [7:0] A_ST_BUSY    = 8'h84;

  // ==========================================================================
  // Field positions
  localparam int DP_VAR_BIT   = 0;
  localparam int DP_NSP_LSB   = 1;
  localparam int DP_NMULT_LSB = 5;
  localparam int DP_TWO_BIT   = 8;
  localparam int FE_MOD_LSB   = 6;
  localparam int P2_RANGE_BIT = 0;
  localparam int NC_THR_LSB   = 8;
  localparam int SUP_OV_LSB   = 8;

  // Modulo codes
  localparam logic [1:0] MOD_360 = 2'h0;
  localparam logic [1:0] MOD_90  = 2'h1;
  localparam logic [1:0] MOD_120 = 2'h2;
  localparam logic [1:0] MOD_180 = 2'h3;

  // Arithmetic constants
  localparam logic [15:0] UNITY      = 16'h4000;
  localparam int          GAIN_SHIFT = 14;
  localparam int          POLY_SHIFT = 15;
  localparam int          NC_SHIFT   = 8;
  localparam int          STEP_ONE   = 11;
  localparam int          STEP_TWO   = 12;
  localparam longint      SPEED_NUM  = 16384;
  localparam longint      RANGE_LO   = 1000;
  localparam longint      RANGE_HI   = 5000;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000, ST_CHAN  = 3'b001, ST_ANGLE = 3'b010, ST_SCALE = 3'b011,
    ST_LIN   = 3'b100, ST_FINAL = 3'b101, ST_SPEED = 3'b110
  } aoc_state_t;

  typedef struct packed {
    logic [15:0]      temp;   // signed temperature code
    logic [2:0][15:0] ch;     // signed raw channels
    logic [15:0]      angle;  // unsigned full circle
  } aoc_sample_t;

  typedef struct packed {
    logic [15:0]      position;
    logic [15:0]      speed;
    logic [2:0][15:0] ch;     // corrected channels
  } aoc_result_t;

  function automatic logic [15:0] aoc_cfg_reset(input int idx);
    if (idx == int'(I_GAIN_POLY) || idx == int'(I_GAIN_POLY) + 3 ||
        idx == int'(I_GAIN_POLY) + 6 || idx == int'(I_SCALE_GAIN) ||
        idx == int'(I_OUT_GAIN) || idx == int'(I_SPD_GAIN)) begin
      return UNITY;
    end else if (idx == int'(I_OUT_HI) || idx == int'(I_SPD_HI)) begin
      return 16'h7fff;
    end else if (idx == int'(I_OUT_LO) || idx == int'(I_SPD_LO)) begin
      return 16'h8000;
    end
    return 16'h0000;
  endfunction

endpackage

//--- aoc_conditioning.sv
// Angle output conditioning chain: correction, shift, fold, scale, linearize,
// noise filter, final gain and clamp, plus the angle speed path.
// Assumes samples arrive on ref_clk from the front-end over the valid/ready handshake.
//
// Contract
// - Subtract temperature polynomial offset per channel
// - Scale each channel by temperature polynomial gain
// - Shift angle by temperature polynomial zero position
// - Fold angle into 90/120/180 or full circle
// - Datapath bits 7:5 give power-of-two multiplier
// - Scale position by programmable setpoint gain
// - Add programmable setpoint offset
// - Fixed: 33 points, or 17 per channel
// - Fixed x evenly spaced over signed span
// - Datapath bit 0 selects programmable x
// - Points 16-bit signed, zero reset, y relative
// - Interpolate linearly between bracketing points
// - Bits 4:1 slope exponent, set for variable
// - Low-pass only changes below threshold, attenuation cutoff
// - No added latency; large changes pass through
// - Filter off when both fields zero
// - Final signed offset and gain; negative inverts
// - Clamp output between low and high limits
// - Speed range selects 1000 or 5000 deg/s
// - Speed path applies signed offset and gain
// - Clamp speed between low and high limits
// - Supply word: overvoltage high byte, undervoltage low
// - Raw speed is 16384 times delta over range
`timescale 1ns/1ns
`default_nettype none

module aoc_conditioning
  import aoc_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Sample from front-end
  input  wire logic        sample_valid,
  output logic             sample_ready,
  input  wire aoc_sample_t sample,
  // Result to protocol stage
  output logic             result_valid,
  output aoc_result_t      result,
  // Supply supervision levels
  output logic      [7:0]  undervoltage_threshold,
  output logic      [7:0]  overvoltage_threshold
);

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] sat16(input logic signed [63:0] v);
    if (v > 64'sh0000_0000_0000_7fff) begin
      return 16'h7fff;
    end else if (v < $signed(64'hffff_ffff_ffff_8000)) begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction

  function automatic logic [15:0] poly(input logic [15:0] c0, input logic [15:0] c1,
                                       input logic [15:0] c2, input logic [15:0] t);
    logic signed [63:0] sq;
    logic signed [63:0] acc;
    sq  = (64'($signed(t)) * 64'($signed(t))) >>> POLY_SHIFT;
    acc = 64'($signed(c0)) + ((64'($signed(c1)) * 64'($signed(t))) >>> POLY_SHIFT)
        + ((64'($signed(c2)) * sq) >>> POLY_SHIFT);
    return sat16(acc);
  endfunction

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    if ($signed(v) > $signed(hi)) begin
      return hi;
    end else if ($signed(v) < $signed(lo)) begin
      return lo;
    end
    return v;
  endfunction

  function automatic logic cfg_hit(input logic [7:0] a);
    logic [6:0] i;
    i = a[6:0];
    return !a[7] && (i <= I_SUPPLY ||
           (i >= I_PX_BASE && i < I_PX_BASE + 7'(NPTS_ONE)) ||
           (i >= I_PY_BASE && i < I_PY_BASE + 7'(NPTS_ONE)));
  endfunction

  // ==========================================================================
  // Configuration store
  logic [15:0] cfg_r [0:CFG_DEPTH-1];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CFG_DEPTH; i++) begin
        cfg_r[i] <= aoc_cfg_reset(i);  // Points clear to zero
      end
    end else if (reg_wr && cfg_hit(reg_addr)) begin
      cfg_r[reg_addr[6:0]] <= reg_wdata;
    end
  end

  logic [15:0] dp_setup;
  logic [15:0] nc_cfg;
  logic [1:0]  mod_sel;
  logic        var_pts;
  logic        two_ch;
  logic [4:0]  nsp_shift;
  logic [2:0]  nmult;
  assign dp_setup  = cfg_r[I_DATAPATH];
  assign nc_cfg    = cfg_r[I_NOISE_CFG];
  assign mod_sel   = cfg_r[I_FRONTEND][FE_MOD_LSB +: 2];
  assign var_pts   = dp_setup[DP_VAR_BIT];
  assign two_ch    = dp_setup[DP_TWO_BIT];
  assign nsp_shift = 5'(dp_setup[DP_NSP_LSB +: 4]) + 5'h01;  // 2..65536
  assign nmult     = dp_setup[DP_NMULT_LSB +: 3];
  assign overvoltage_threshold  = cfg_r[I_SUPPLY][SUP_OV_LSB +: 8];
  assign undervoltage_threshold = cfg_r[I_SUPPLY][7:0];

  // ==========================================================================
  // Sequencer
  aoc_state_t state_r;
  aoc_sample_t smp_r;

  assign sample_ready = (state_r == ST_IDLE);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE:  state_r <= sample_valid ? ST_CHAN : ST_IDLE;
        ST_CHAN:  state_r <= ST_ANGLE;
        ST_ANGLE: state_r <= ST_SCALE;
        ST_SCALE: state_r <= ST_LIN;
        ST_LIN:   state_r <= ST_FINAL;
        ST_FINAL: state_r <= ST_SPEED;
        ST_SPEED: state_r <= ST_IDLE;
        default:  state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      smp_r <= '0;
    end else if (sample_valid && sample_ready) begin
      smp_r <= sample;
    end
  end

  // ==========================================================================
  // Channel correction
  logic [2:0][15:0] chan_r;
  for (genvar g = 0; g < 3; g++) begin : g_chan
    localparam logic [6:0] OI = I_OFF_POLY + 7'(3 * g);
    localparam logic [6:0] GI = I_GAIN_POLY + 7'(3 * g);
    logic [15:0] off_p;
    logic [15:0] gain_p;
    assign off_p  = poly(cfg_r[OI], cfg_r[OI + 7'h01], cfg_r[OI + 7'h02], smp_r.temp);
    assign gain_p = poly(cfg_r[GI], cfg_r[GI + 7'h01], cfg_r[GI + 7'h02], smp_r.temp);
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        chan_r[g] <= 16'h0000;
      end else if (state_r == ST_CHAN) begin
        chan_r[g] <= sat16(((64'($signed(smp_r.ch[g])) - 64'($signed(off_p)))
                            * 64'($signed(gain_p))) >>> GAIN_SHIFT);
      end
    end
  end

  // ==========================================================================
  // Reference shift and modulo
  logic [15:0] zero_p;
  logic [15:0] shifted;
  logic [15:0] mod_r;
  assign zero_p  = poly(cfg_r[I_ZERO_POLY], cfg_r[I_ZERO_POLY + 7'h01],
                        cfg_r[I_ZERO_POLY + 7'h02], smp_r.temp);
  assign shifted = smp_r.angle - zero_p;  // Wraps around the circle

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mod_r <= 16'h0000;
    end else if (state_r == ST_ANGLE) begin
      unique case (mod_sel)  // Sub-range stretched back to full span
        MOD_360: mod_r <= shifted;
        MOD_90:  mod_r <= {shifted[13:0], 2'b00};
        MOD_120: mod_r <= 16'(shifted * 16'h0003);
        MOD_180: mod_r <= {shifted[14:0], 1'b0};
      endcase
    end
  end

  // ==========================================================================
  // Setpoint scaling
  logic [15:0] scaled_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scaled_r <= 16'h0000;
    end else if (state_r == ST_SCALE) begin
      // Offset-binary angle centred on zero before the gain
      scaled_r <= sat16((((64'($signed(mod_r ^ 16'h8000)) * 64'($signed(cfg_r[I_SCALE_GAIN])))
                          <<< nmult) >>> GAIN_SHIFT) + 64'($signed(cfg_r[I_SCALE_OFF])));
    end
  end

  // ==========================================================================
  // Setpoint linearization
  logic signed [31:0] px [0:NPTS_ONE-1];
  logic signed [31:0] py [0:NPTS_ONE-1];
  logic        [5:0]  seg;
  logic        [15:0] lin_nxt;
  logic        [15:0] lin_r;

  always_comb begin
    logic [4:0]         step;
    logic signed [63:0] xa;
    logic signed [63:0] xb;
    logic signed [63:0] ya;
    logic signed [63:0] yb;
    logic signed [63:0] dx;
    logic signed [63:0] slope;
    logic [5:0]         npts;
    step    = two_ch ? 5'(STEP_TWO) : 5'(STEP_ONE);
    npts    = two_ch ? 6'(NPTS_TWO) : 6'(NPTS_ONE);
    seg     = 6'h00;
    lin_nxt = 16'h0000;
    for (int n = 0; n < NPTS_ONE; n++) begin
      // Fixed x spread evenly from -32768 programmable x
      px[n] = var_pts ? 32'($signed(cfg_r[I_PX_BASE + 7'(n)]))
                      : (32'(n) <<< step) - 32'sh0000_8000;
      if (px[n] > 32'sh0000_7fff) begin
        px[n] = 32'sh0000_7fff;
      end
      py[n] = px[n] + 32'($signed(cfg_r[I_PY_BASE + 7'(n)]));  // y relative
    end
    if (!var_pts) begin
      seg = 6'({1'b0, ~scaled_r[15], scaled_r[14:0]} >> step);
    end else begin
      for (int n = 1; n < NPTS_ONE - 1; n++) begin
        if (6'(n) < npts - 6'h01 && px[n] <= 32'($signed(scaled_r))) begin
          seg = 6'(n);
        end
      end
    end
    xa    = 64'(px[seg]);
    xb    = 64'(px[seg + 6'h01]);
    ya    = 64'(py[seg]);
    yb    = 64'(py[seg + 6'h01]);
    dx    = 64'($signed(scaled_r)) - xa;
    slope = 64'sh0;
    if (!var_pts) begin
      lin_nxt = sat16(ya + ((dx * (yb - ya)) >>> step));
    end else if (xb > xa) begin
      slope   = ((yb - ya) <<< nsp_shift) / (xb - xa);
      lin_nxt = sat16(ya + ((dx * slope) >>> nsp_shift));
    end else begin
      lin_nxt = sat16(ya);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lin_r <= 16'h0000;
    end else if (state_r == ST_LIN) begin
      lin_r <= lin_nxt;
    end
  end

  // ==========================================================================
  // Noise filter and final stage, one cycle together
  logic [15:0] noise_nxt;
  logic [15:0] noise_r;
  logic [15:0] out_nxt;
  logic [15:0] out_r;
  logic [15:0] out_prev_r;

  always_comb begin
    logic signed [63:0] delta;
    logic signed [63:0] mag;
    delta = 64'($signed(lin_r)) - 64'($signed(noise_r));
    mag   = (delta < 0) ? -delta : delta;
    // Small changes low-passed; big ones pass straight, full width kept
    if (nc_cfg == 16'h0000 || mag >= 64'(nc_cfg[NC_THR_LSB +: 8])) begin
      noise_nxt = lin_r;
    end else begin
      noise_nxt = sat16(64'($signed(noise_r))
                        + ((delta * 64'($signed({1'b0, nc_cfg[7:0]}))) >>> NC_SHIFT));
    end
    out_nxt = clamp(sat16(((64'($signed(noise_nxt)) * 64'($signed(cfg_r[I_OUT_GAIN])))
                           >>> GAIN_SHIFT) + 64'($signed(cfg_r[I_OUT_OFF]))),
                    cfg_r[I_OUT_LO], cfg_r[I_OUT_HI]);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      noise_r <= 16'h0000;
      out_r   <= 16'h0000;
    end else if (state_r == ST_FINAL) begin
      noise_r <= noise_nxt;
      out_r   <= out_nxt;
    end
  end

  // ==========================================================================
  // Angle speed path
  logic [15:0] speed_raw;
  logic [15:0] speed_nxt;
  logic [15:0] speed_r;

  always_comb begin
    logic signed [63:0] diff;
    diff      = 64'($signed(out_r)) - 64'($signed(out_prev_r));
    speed_raw = sat16((diff * SPEED_NUM)
                      / (cfg_r[I_PROTO_TWO][P2_RANGE_BIT] ? RANGE_HI : RANGE_LO));
    speed_nxt = clamp(sat16(((64'($signed(speed_raw)) * 64'($signed(cfg_r[I_SPD_GAIN])))
                             >>> GAIN_SHIFT) + 64'($signed(cfg_r[I_SPD_OFF]))),
                      cfg_r[I_SPD_LO], cfg_r[I_SPD_HI]);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      speed_r      <= 16'h0000;
      out_prev_r   <= 16'h0000;
      result_valid <= 1'b0;
      result       <= '0;
    end else begin
      result_valid <= (state_r == ST_SPEED);
      if (state_r == ST_SPEED) begin
        speed_r    <= speed_nxt;
        out_prev_r <= out_r;
        result     <= '{position: out_r, speed: speed_nxt, ch: chan_r};
      end
    end
  end

  // ==========================================================================
  // Register read, data stands one cycle only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (cfg_hit(reg_addr)) begin
      reg_rdata <= cfg_r[reg_addr[6:0]];
    end else begin
      unique case (reg_addr)
        A_ST_OUT:   reg_rdata <= out_r;
        A_ST_SPEED: reg_rdata <= speed_r;
        A_ST_LIN:   reg_rdata <= lin_r;
        A_ST_NOISE: reg_rdata <= noise_r;
        A_ST_BUSY:  reg_rdata <= {13'h0000, state_r};
        default:    reg_rdata <= 16'h0000;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  a_stage_order: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == ST_CHAN |=> state_r == ST_ANGLE ##1 state_r == ST_SCALE ##1
    state_r == ST_LIN ##1 state_r == ST_FINAL ##1 state_r == ST_SPEED ##1 result_valid)
    else $error("stage order broken");
  a_fold_ninety: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == ST_ANGLE && mod_sel == MOD_90 |=> mod_r[1:0] == 2'b00)
    else $error("modulo 90 not folded");
  a_out_clamped: assert property (@(posedge ref_clk) disable iff (rst)
    result_valid && $signed(cfg_r[I_OUT_LO]) <= $signed(cfg_r[I_OUT_HI]) |->
    $signed(result.position) <= $signed(cfg_r[I_OUT_HI]) &&
    $signed(result.position) >= $signed(cfg_r[I_OUT_LO]))
    else $error("output outside clamp");
  a_speed_clamped: assert property (@(posedge ref_clk) disable iff (rst)
    result_valid && $signed(cfg_r[I_SPD_LO]) <= $signed(cfg_r[I_SPD_HI]) |->
    $signed(result.speed) <= $signed(cfg_r[I_SPD_HI]) &&
    $signed(result.speed) >= $signed(cfg_r[I_SPD_LO]))
    else $error("speed outside clamp");
  a_filter_off: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == ST_FINAL && nc_cfg == 16'h0000 |=> noise_r == $past(lin_r))
    else $error("disabled filter altered data");
  a_filter_big: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == ST_FINAL && lin_r == 16'h7fff && noise_r == 16'h8000 |=> noise_r == 16'h7fff)
    else $error("large step was filtered");
  a_speed_still: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == ST_SPEED && out_r == out_prev_r |-> speed_raw == 16'h0000)
    else $error("speed nonzero at rest");
  a_supply_split: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(reg_wr && reg_addr == 8'(I_SUPPLY)) |=>
    overvoltage_threshold == $past(reg_wdata[15:8]) &&
    undervoltage_threshold == $past(reg_wdata[7:0]))
    else $error("supply levels misplaced");
  a_fixed_grid: assert property (@(posedge ref_clk) disable iff (rst)
    !var_pts && !two_ch |-> px[1] == -32'sh0000_7800 && px[16] == 32'sh0)
    else $error("fixed grid misplaced");

endmodule // aoc_conditioning

`default_nettype wire

//--- aoc_front_model.sv
// Front-end model: hands samples to the chain over the valid/ready handshake.
// Assumes the chain takes a sample on the edge where valid and ready are high.
`timescale 1ns/1ns
`default_nettype none
module aoc_front_model
  import aoc_pkg::*;
(
  // Clock
  input  wire logic   ref_clk,
  // Handshake
  input  wire logic   sample_ready,
  output logic        sample_valid,
  output aoc_sample_t sample
);
  aoc_sample_t load_r;
  aoc_sample_t idle_r;
  // ==========================================================================
  // Idle pattern flips every cycle so a stale word never looks valid
  assign sample = sample_valid ? load_r : idle_r;
  initial begin
    sample_valid = 1'b0;
    idle_r = '0;
  end
  always @(posedge ref_clk) begin
    idle_r <= ~idle_r;
  end
  // Hold the request until ready is seen high at an edge
  task automatic send(input aoc_sample_t s, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge ref_clk);
    load_r <= s;
    sample_valid <= 1'b1;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge ref_clk);
      ok = sample_ready === 1'b1;
    end
    sample_valid <= 1'b0;
  endtask
endmodule // aoc_front_model
`default_nettype wire

//--- test_angle_output_conditioning.sv
// Self-checking bench for the angle output conditioning chain.
// Assumes the front-end model drives samples; registers use the strobe port.
`timescale 1ns/1ns
`default_nettype none
module test_angle_output_conditioning
  import aoc_pkg::*;
;
  logic               ref_clk;
  logic               rst;
  logic        [7:0]  reg_addr;
  logic        [15:0] reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic        [15:0] reg_rdata;
  logic               sample_valid;
  logic               sample_ready;
  aoc_sample_t        sample;
  logic               result_valid;
  aoc_result_t        result;
  logic        [7:0]  uv_thr;
  logic        [7:0]  ov_thr;
  int                 num_errors;
  int                 n_tests;
  aoc_result_t        exq[$];
  logic        [15:0] rdq[$];
  logic               rd_d;
  logic        [31:0] lfsr_r;
  int                 prev_pos;
  int                 spd_rng;
  int                 spd_hi;
  int                 spd_off;
  bit                 ch_adj;
  aoc_conditioning uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample(sample),
    .result_valid(result_valid), .result(result), .undervoltage_threshold(uv_thr),
    .overvoltage_threshold(ov_thr));
  aoc_front_model fe (.ref_clk(ref_clk), .sample_ready(sample_ready),
    .sample_valid(sample_valid), .sample(sample));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ==========================================================================
  // Checking
  task automatic stop_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_res(input aoc_result_t got, input aoc_result_t exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (result_valid === 1'b1) begin
      cmp_res(result, exq.size() != 0 ? exq.pop_front() : '1);
    end
    if (rd_d === 1'b1) begin
      cmp_reg(reg_rdata, rdq.pop_front());
    end
    rd_d <= reg_rd;
  end
  // ==========================================================================
  // Stimulus
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int sx(input logic [15:0] v);
    return int'(signed'(v));
  endfunction
  task automatic w(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic r(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rdq.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  // Speed model truncates toward zero, then offset, then clamp
  task automatic run(input logic [15:0] a, input int pos);
    aoc_sample_t s;
    aoc_result_t e;
    longint      sp;
    bit          ok;
    int          n;
    lfsr_r = nx(lfsr_r);
    s.temp = lfsr_r[31:16];
    for (n = 0; n < 3; n++) begin
      s.ch[n] = {{4{lfsr_r[n*5+11]}}, lfsr_r[n*5 +: 12]};
    end
    s.angle = a;
    e.ch = s.ch;
    if (ch_adj) begin
      e.ch[0] = {s.ch[0][15], s.ch[0][15:1]};
      e.ch[1] = s.ch[1] - 16'd100;
    end
    sp = longint'(pos - prev_pos) * 16384 / spd_rng;
    sp = (sp > 32767 ? 32767 : (sp < -32768 ? -32768 : sp)) + spd_off;
    sp = sp > spd_hi ? spd_hi : (sp < -32768 ? -32768 : sp);
    prev_pos = pos;
    e.position = 16'(pos);
    e.speed = 16'(sp);
    exq.push_back(e);
    fe.send(s, ok);
    for (n = 0; n < 20 && exq.size() != 0; n++) begin
      @(posedge ref_clk);
    end
    if (!ok || exq.size() != 0) begin
      num_errors++;
      stop_test();
    end
  endtask
  initial begin
    int          i;
    logic [15:0] m;
    logic [15:0] ang;
    rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    num_errors = 0;
    n_tests = 0;
    rd_d = 1'b0;
    lfsr_r = 32'h322c7262;
    prev_pos = 0;
    spd_rng = 1000;
    spd_hi = 32767;
    spd_off = 0;
    ch_adj = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    r(8'(I_OUT_GAIN), 16'h4000);
    r(8'(I_OUT_LO), 16'h8000);
    r(8'(I_SPD_HI), 16'h7fff);
    r(8'(I_PY_BASE) + 8'd32, 16'h0000);
    r(8'h7f, 16'h0000);
    w(A_ST_OUT, 16'h1234);
    r(A_ST_OUT, 16'h0000);
    w(8'(I_SUPPLY), 16'ha55a);
    r(8'(I_SUPPLY), 16'ha55a);
    cmp_reg({ov_thr, uv_thr}, 16'ha55a);
    ang = 16'h1000;
    for (i = 0; i < 8; i++) begin
      ang = ang + 16'd125 * lfsr_r[2:0];
      run(ang, sx(ang ^ 16'h8000));
    end
    w(8'(I_GAIN_POLY), 16'h2000);
    w(8'(I_OFF_POLY) + 8'd3, 16'd100);
    ch_adj = 1'b1;
    run(ang, sx(ang ^ 16'h8000));
    ch_adj = 1'b0;
    w(8'(I_GAIN_POLY), 16'h4000);
    w(8'(I_OFF_POLY) + 8'd3, 16'h0000);
    for (i = 0; i < 4; i++) begin
      w(8'(I_FRONTEND), 16'(i << 6));
      m = i == 1 ? 16'h48d0 : i == 2 ? 16'h369c : i == 3 ? 16'h2468 : 16'h1234;
      run(16'h1234, sx(m ^ 16'h8000));
    end
    w(8'(I_FRONTEND), 16'h0000);
    w(8'(I_DATAPATH), 16'h0060);
    w(8'(I_SCALE_GAIN), 16'h0800);
    w(8'(I_SCALE_OFF), 16'd100);
    run(16'h8200, 612);
    w(8'(I_DATAPATH), 16'h0000);
    w(8'(I_SCALE_GAIN), 16'h4000);
    w(8'(I_SCALE_OFF), 16'h0000);
    w(8'(I_PY_BASE) + 8'd16, 16'h0400);
    run(16'h8000, 1024);
    run(16'h8400, 1536);
    w(8'(I_PY_BASE) + 8'd16, 16'h0000);
    w(8'(I_NOISE_CFG), 16'h1080);
    run(16'h9000, 4096);
    run(16'h9008, 4100);
    run(16'h9100, 4352);
    run(16'h90fc, 4350);
    w(8'(I_NOISE_CFG), 16'h0000);
    run(16'h9104, 4356);
    w(8'(I_OUT_GAIN), 16'hc000);
    run(16'h8800, -2048);
    w(8'(I_OUT_GAIN), 16'h4000);
    w(8'(I_OUT_OFF), 16'hff00);
    run(16'h8800, 1792);
    w(8'(I_OUT_HI), 16'h0400);
    run(16'h8800, 1024);
    w(8'(I_OUT_LO), 16'h0100);
    run(16'h8000, 256);
    w(8'(I_OUT_HI), 16'h7fff);
    w(8'(I_OUT_LO), 16'h8000);
    w(8'(I_PROTO_TWO), 16'h0001);
    spd_rng = 5000;
    w(8'(I_SPD_HI), 16'h0800);
    spd_hi = 2048;
    run(16'h8100, 0);
    run(16'h8371, 625);
    run(16'h8853, 1875);
    w(8'(I_SPD_OFF), 16'd10);
    spd_off = 10;
    run(16'h8853, 1875);
    w(8'(I_DATAPATH), 16'h001f);
    w(8'(I_PX_BASE), 16'h8000);
    w(8'(I_PY_BASE) + 8'd1, 16'h0400);
    run(16'h4000, -16128);
    repeat (4) @(posedge ref_clk);
    stop_test();
  end
endmodule // test_angle_output_conditioning
`default_nettype wire
